/* File: hw/hgc_phase_timer.sv */
// Phase timer: counts a programmed width plus the fixed extra periods.
// Assumes tick is a one-cycle oscillator enable from the parent.
`timescale 1ns/1ps
module hgc_phase_timer
  import hgc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic [7:0] count,
  // Status
  output logic            busy,
  output logic            done
);

  logic [8:0] remain;
  wire        last_tick = busy && tick && (remain == 9'd1);

  // Width is taken at start, so later writes only affect the next phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remain <= 9'd0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= last_tick;
      if (start) begin
        remain <= {1'b0, count} + HGC_EXTRA_PERIODS;
        busy   <= 1'b1;
      end else if (busy && tick) begin
        remain <= remain - 9'd1;
        busy   <= !last_tick;
      end
    end
  end

endmodule : hgc_phase_timer

/* File: hw/hgc_pkg.sv */
// Shared constants and carrier types for the hub global control registers.
// Assumes a single 25 MHz clock that also serves as the oscillator time base.
package hgc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] HGC_OFF_HIGH_COUNT = 8'h0a;
  localparam logic [7:0] HGC_OFF_LOW_COUNT  = 8'h0b;
  localparam logic [7:0] HGC_OFF_RX_CTL     = 8'h0c;
  localparam logic [7:0] HGC_OFF_PIN_VOLTAGE_CONTROL     = 8'h0d;
  localparam logic [7:0] HGC_OFF_PIN_LEVEL  = 8'h0e;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] HGC_RST_HIGH_COUNT = 8'h7a;
  localparam logic [7:0] HGC_RST_LOW_COUNT  = 8'h7a;
  localparam logic [3:0] HGC_RST_ROUTE      = 4'h0;
  localparam logic [3:0] HGC_RST_RX_EN      = 4'hf;
  localparam logic [3:0] HGC_IO_RESERVED    = 4'h9;
  localparam logic [1:0] HGC_MODE_LOW_V     = 2'h0;
  localparam logic [1:0] HGC_MODE_HIGH_V    = 2'h3;
  localparam logic [7:0] HGC_READ_ZERO      = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int HGC_RX_ROUTE_LSB = 4;
  localparam int HGC_RX_ROUTE_MSB = 7;
  localparam int HGC_RX_EN_LSB    = 0;
  localparam int HGC_RX_EN_MSB    = 3;
  localparam int HGC_IO_HV_BIT    = 7;
  localparam int HGC_IO_OV_BIT    = 6;
  localparam int HGC_IO_MODE_LSB  = 4;
  localparam int HGC_IO_MODE_MSB  = 5;
  localparam int HGC_IO_RSV_LSB   = 0;
  localparam int HGC_IO_RSV_MSB   = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int          HGC_OSC_PERIOD_NS = 40;
  localparam int          HGC_CLK_PERIOD_NS = 40;
  localparam int          HGC_OSC_DIV_RAW   = HGC_OSC_PERIOD_NS / HGC_CLK_PERIOD_NS;
  localparam int          HGC_OSC_DIV       = (HGC_OSC_DIV_RAW < 1) ? 1 : HGC_OSC_DIV_RAW;
  localparam logic [8:0]  HGC_EXTRA_PERIODS = 9'd5;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hgc_reg_req_t;

  typedef struct packed {
    logic [3:0] route;
    logic [3:0] rx_en;
    logic       hv_sel;
    logic [1:0] supply_mode;
  } hgc_ctrl_t;

  typedef enum logic [1:0] {HGC_M_IDLE, HGC_M_LOW, HGC_M_RELEASE, HGC_M_HIGH} hgc_mstate_t;

endpackage : hgc_pkg

/* File: hw/hgc_regs.sv */
// Hub global control registers with local clock timing and pin voltage logic.
// Assumes synchronous inputs and an internal register port behind the I2C slave.
//
// Contract
// - Master clock high width comes from an 8-bit count of 40 ns periods.
// - Master clock high phase lasts at least high count plus five periods.
// - High count resets to 0x7a.
// - Master clock low width comes from its own 8-bit count plus five periods.
// - Slave stretch uses the low count as data setup before releasing clock.
// - Low count resets to 0x7a.
// - Bits 7..4 route channels 3..0 to slave port 0 or 1; reset 0.
// - Bits 3..0 enable receivers 3..0; reset 1, write 0 disables.
// - I/O control bit 7 selects 1.8 V when 0, 3.3 V when 1.
// - Override 0 drives voltage controls from detection; 1 uses written values.
// - With override 0, reads of select and mode show the detected level.
// - Supply mode bits 5:4 encode 00 as 1.8 V, 11 as 3.3 V; reset 00.
// - Pin level register reads current levels on all eight GPIO pins.
// - Pin n maps to bit n; the pin level register is read-only.
`timescale 1ns/1ps
module hgc_regs
  import hgc_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Register port
  input  wire hgc_pkg::hgc_reg_req_t reg_req,
  output logic [7:0]              rd_data,
  output logic                    rd_valid,
  // Pin sensing
  input  wire logic               io_level_detect,
  input  wire logic [7:0]         gpio_in,
  // Control outputs
  output hgc_pkg::hgc_ctrl_t      ctrl,
  // Local master and slave clocking
  input  wire logic               master_enable,
  input  wire logic               slave_stretch_req,
  output logic                    slave_setup_busy,
  // Open-drain clock pin
  input  wire logic               scl_in,
  output logic                    scl_o,
  output logic                    scl_oe
);
  import hgc_pkg::*;

  function automatic logic [1:0] level_mode(input logic high_v);
    level_mode = high_v ? HGC_MODE_HIGH_V : HGC_MODE_LOW_V;
  endfunction : level_mode

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] high_count;
  logic [7:0] low_count;
  logic [3:0] route;
  logic [3:0] rx_en;
  logic       hv_stored;
  logic       io_override;
  logic [1:0] mode_stored;

  wire wr_high = reg_req.wr && (reg_req.addr == HGC_OFF_HIGH_COUNT);
  wire wr_low  = reg_req.wr && (reg_req.addr == HGC_OFF_LOW_COUNT);
  wire wr_rx   = reg_req.wr && (reg_req.addr == HGC_OFF_RX_CTL);
  wire wr_io   = reg_req.wr && (reg_req.addr == HGC_OFF_PIN_VOLTAGE_CONTROL);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_count  <= HGC_RST_HIGH_COUNT;
      low_count   <= HGC_RST_LOW_COUNT;
      route       <= HGC_RST_ROUTE;
      rx_en       <= HGC_RST_RX_EN;
      hv_stored   <= 1'b0;
      io_override <= 1'b0;
      mode_stored <= HGC_MODE_LOW_V;
    end else begin
      if (wr_high) high_count <= reg_req.wdata;
      if (wr_low) low_count <= reg_req.wdata;
      if (wr_rx) begin
        route <= reg_req.wdata[HGC_RX_ROUTE_MSB:HGC_RX_ROUTE_LSB];
        rx_en <= reg_req.wdata[HGC_RX_EN_MSB:HGC_RX_EN_LSB];
      end
      if (wr_io) begin
        hv_stored   <= reg_req.wdata[HGC_IO_HV_BIT];
        io_override <= reg_req.wdata[HGC_IO_OV_BIT];
        mode_stored <= reg_req.wdata[HGC_IO_MODE_MSB:HGC_IO_MODE_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Voltage selection and control outputs
  wire       eff_hv   = io_override ? hv_stored : io_level_detect;
  wire [1:0] eff_mode = io_override ? mode_stored : level_mode(io_level_detect);

  hgc_ctrl_t next_ctrl;
  assign next_ctrl = '{route: route, rx_en: rx_en, hv_sel: eff_hv, supply_mode: eff_mode};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= '{route: HGC_RST_ROUTE, rx_en: HGC_RST_RX_EN, hv_sel: 1'b0,
                supply_mode: HGC_MODE_LOW_V};
    end else begin
      ctrl <= next_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; reserved bits are constant so writes cannot disturb them
  wire [7:0] io_read = {eff_hv, io_override, eff_mode, HGC_IO_RESERVED};

  logic [7:0] next_rd_data;
  always_comb begin
    unique case (reg_req.addr)
      HGC_OFF_HIGH_COUNT: next_rd_data = high_count;
      HGC_OFF_LOW_COUNT:  next_rd_data = low_count;
      HGC_OFF_RX_CTL:     next_rd_data = {route, rx_en};
      HGC_OFF_PIN_VOLTAGE_CONTROL:     next_rd_data = io_read;
      HGC_OFF_PIN_LEVEL:  next_rd_data = gpio_in;
      default:            next_rd_data = HGC_READ_ZERO;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data  <= HGC_READ_ZERO;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= reg_req.rd;
      if (reg_req.rd) rd_data <= next_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick; at 25 MHz the divider collapses to every cycle
  logic [7:0] div_cnt;
  wire        osc_tick = (div_cnt == 8'(HGC_OSC_DIV - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) div_cnt <= 8'h00;
    else     div_cnt <= osc_tick ? 8'h00 : div_cnt + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local master clock generator
  hgc_mstate_t mstate;
  hgc_mstate_t next_mstate;
  logic        m_busy;
  logic        m_done;
  logic        m_start;
  logic [7:0]  m_count;

  always_comb begin
    next_mstate = mstate;
    m_start     = 1'b0;
    m_count     = low_count;
    unique case (mstate)
      HGC_M_IDLE: begin
        if (master_enable) begin
          next_mstate = HGC_M_LOW;
          m_start     = 1'b1;
        end
      end
      HGC_M_LOW: begin
        if (m_done) next_mstate = HGC_M_RELEASE;
      end
      // High time counts only once the wire is seen high, so a slave stretch held at release
      // never eats into the programmed high phase
      HGC_M_RELEASE: begin
        if (scl_in) begin
          next_mstate = HGC_M_HIGH;
          m_start     = 1'b1;
          m_count     = high_count;
        end
      end
      HGC_M_HIGH: begin
        m_count = high_count;
        if (m_done) begin
          next_mstate = master_enable ? HGC_M_LOW : HGC_M_IDLE;
          m_start     = master_enable;
          m_count     = low_count;
        end
      end
    endcase
  end

  hgc_phase_timer u_master_timer (
    .clk   (clk),
    .rst   (rst),
    .tick  (osc_tick),
    .start (m_start),
    .count (m_count),
    .busy  (m_busy),
    .done  (m_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Slave setup stretch
  logic s_busy;
  logic s_done;
  wire  s_start = slave_stretch_req && !s_busy && !slave_setup_busy;

  hgc_phase_timer u_slave_timer (
    .clk   (clk),
    .rst   (rst),
    .tick  (osc_tick),
    .start (s_start),
    .count (low_count),
    .busy  (s_busy),
    .done  (s_done)
  );

  wire next_stretch = s_start || (slave_setup_busy && !s_done);
  wire next_scl_oe  = (next_mstate == HGC_M_LOW) || next_stretch;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mstate           <= HGC_M_IDLE;
      slave_setup_busy <= 1'b0;
      scl_oe           <= 1'b0;
      scl_o            <= 1'b0;
    end else begin
      mstate           <= next_mstate;
      slave_setup_busy <= next_stretch;
      scl_oe           <= next_scl_oe;
      scl_o            <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks; helper counters measure each master phase
  logic [8:0] high_len;
  logic [8:0] low_len;
  logic [7:0] high_at_start;
  logic [7:0] low_at_start;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_len      <= 9'd0;
      low_len       <= 9'd0;
      high_at_start <= HGC_RST_HIGH_COUNT;
      low_at_start  <= HGC_RST_LOW_COUNT;
    end else begin
      high_len <= (mstate == HGC_M_HIGH) ? high_len + 9'd1 : 9'd0;
      low_len  <= (mstate == HGC_M_LOW) ? low_len + 9'd1 : 9'd0;
      if (m_start && (m_count == high_count) && (mstate == HGC_M_RELEASE))
        high_at_start <= high_count;
      if (m_start && (mstate != HGC_M_RELEASE)) low_at_start <= low_count;
    end
  end

  chk_high_width: assert property (@(posedge clk) disable iff (rst)
    (mstate == HGC_M_HIGH) && (next_mstate != HGC_M_HIGH)
      |-> (high_len + 9'd1 >= {1'b0, high_at_start} + HGC_EXTRA_PERIODS))
    else $error("master high phase too short");

  chk_low_width: assert property (@(posedge clk) disable iff (rst)
    (mstate == HGC_M_LOW) && (next_mstate != HGC_M_LOW)
      |-> (low_len + 9'd1 >= {1'b0, low_at_start} + HGC_EXTRA_PERIODS))
    else $error("master low phase too short");

  chk_low_drives_pin: assert property (@(posedge clk) disable iff (rst)
    (mstate == HGC_M_LOW) |-> scl_oe)
    else $error("clock not pulled low in low phase");

  chk_low_timer_run: assert property (@(posedge clk) disable iff (rst)
    (mstate == HGC_M_LOW) |-> (m_busy || m_done))
    else $error("low phase without running timer");

  chk_route_write: assert property (@(posedge clk) disable iff (rst)
    wr_rx |=> ##1 (ctrl.route == $past(reg_req.wdata[7:4], 2)))
    else $error("channel route not applied");

  chk_rx_enable: assert property (@(posedge clk) disable iff (rst)
    wr_rx |=> ##1 (ctrl.rx_en == $past(reg_req.wdata[3:0], 2)))
    else $error("receiver enable not applied");

  chk_detect_drive: assert property (@(posedge clk) disable iff (rst)
    !io_override |=> (ctrl.hv_sel == $past(io_level_detect))
      && (ctrl.supply_mode == {2{$past(io_level_detect)}}))
    else $error("detected level not driving controls");

  chk_detect_read: assert property (@(posedge clk) disable iff (rst)
    reg_req.rd && (reg_req.addr == HGC_OFF_PIN_VOLTAGE_CONTROL) && !io_override
      |=> (rd_data[7] == $past(io_level_detect)) && (rd_data[3:0] == HGC_IO_RESERVED))
    else $error("voltage read ignores detection");

  chk_pin_read: assert property (@(posedge clk) disable iff (rst)
    reg_req.rd && (reg_req.addr == HGC_OFF_PIN_LEVEL)
      |=> rd_valid && (rd_data == $past(gpio_in)))
    else $error("pin level read mismatch");

  chk_slave_setup: assert property (@(posedge clk) disable iff (rst)
    $rose(slave_setup_busy) |-> slave_setup_busy [*5])
    else $error("slave setup released early");

endmodule : hgc_regs

/* File: sim/hgc_wire_model.sv */
// Clock wire partner: pull-up plus a far device that may stretch the clock.
// Assumes scl_oe/scl_o come from the block and stretch is set by the bench.
`timescale 1ns/1ps
module hgc_wire_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Block side of the wire
  input  wire logic       scl_o,
  input  wire logic       scl_oe,
  // Bench control
  input  wire logic [7:0] stretch,
  // Wire level
  output logic            scl_in
);
  logic [7:0] hold_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // Far device holds the wire low a few cycles after each release
  // Loaded while driven, so the wire never blips high before the stretch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_cnt <= 8'h00;
    end else begin
      if (scl_oe) begin
        hold_cnt <= stretch;
      end else if (hold_cnt != 8'h00) begin
        hold_cnt <= hold_cnt - 8'h01;
      end
    end
  end
  // Pull-up: a released wire reads high, never the last driven value
  assign scl_in = ((scl_oe && !scl_o) || (hold_cnt != 8'h00)) ? 1'b0 : 1'b1;
endmodule : hgc_wire_model

/* File: sim/test_hgc_regs.sv */
// Self-checking bench for the hub global control registers.
// Assumes hgc_pkg and hgc_regs are compiled first; inputs move on falling edges.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module test_hgc_regs;
  import hgc_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  hgc_reg_req_t req = '0;
  logic [7:0]   rd_data, rv, stretch = 8'h00, gpio_in = 8'h00;
  logic         rd_valid, det = 1'b0, men = 1'b0, sreq = 1'b0, busy, scl_in, scl_o, scl_oe;
  hgc_ctrl_t    ctrl;
  int           error_cnt = 0;
  int           n_compared = 0;
  int           cycles = 0;
  int           n;
  ////////////////////////////////////////////////////////////////////////////
  always #20 clk = ~clk;
  hgc_regs dut (.clk(clk), .rst(rst), .reg_req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .io_level_detect(det), .gpio_in(gpio_in), .ctrl(ctrl), .master_enable(men),
    .slave_stretch_req(sreq), .slave_setup_busy(busy), .scl_in(scl_in), .scl_o(scl_o),
    .scl_oe(scl_oe));
  hgc_wire_model wire_m (.clk(clk), .rst(rst), .scl_o(scl_o), .scl_oe(scl_oe),
    .stretch(stretch), .scl_in(scl_in));
  // Hang guard: whole run is under two hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    for (k = 0; k < 4 && rd_valid !== 1'b1; k++) @(negedge clk);
    `CHK("rd_valid", 1'b1, rd_valid)
    rv = rd_data;
  endtask : rd
  // Count falling edges while scl_oe holds the given level; at level 0 only those with scl_in high
  task automatic cnt_oe(input logic lvl, output int c);
    c = 0;
    while (scl_oe === lvl && c < 300) begin
      if (lvl || scl_in === 1'b1) c++;
      @(negedge clk);
    end
  endtask : cnt_oe
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(HGC_OFF_HIGH_COUNT); `CHK("high_cnt", 8'h7a, rv)
    rd(HGC_OFF_LOW_COUNT);  `CHK("low_cnt", 8'h7a, rv)
    rd(HGC_OFF_RX_CTL);     `CHK("rx_ctl", 8'h0f, rv)
    rd(HGC_OFF_PIN_VOLTAGE_CONTROL);     `CHK("pin_voltage_control", 8'h09, rv)
    `CHK("ctrl", 11'h078, ctrl)
  endtask : t_reset
  task automatic t_rx_port();
    wr(HGC_OFF_RX_CTL, 8'h5a);
    rd(HGC_OFF_RX_CTL); `CHK("rx_ctl", 8'h5a, rv)
    `CHK("route", 4'h5, ctrl.route)
    `CHK("rx_en", 4'ha, ctrl.rx_en)
  endtask : t_rx_port
  task automatic t_io();
    det = 1'b1;
    rd(HGC_OFF_PIN_VOLTAGE_CONTROL); `CHK("io_det", 8'hb9, rv)
    `CHK("hv_det", 3'h7, {ctrl.hv_sel, ctrl.supply_mode})
    wr(HGC_OFF_PIN_VOLTAGE_CONTROL, 8'h40);
    rd(HGC_OFF_PIN_VOLTAGE_CONTROL); `CHK("io_ov", 8'h49, rv)
    `CHK("hv_ov", 3'h0, {ctrl.hv_sel, ctrl.supply_mode})
    wr(HGC_OFF_PIN_VOLTAGE_CONTROL, 8'hf6);
    rd(HGC_OFF_PIN_VOLTAGE_CONTROL); `CHK("io_hv", 8'hf9, rv)
    `CHK("hv_hi", 3'h7, {ctrl.hv_sel, ctrl.supply_mode})
    wr(HGC_OFF_PIN_VOLTAGE_CONTROL, 8'h30);
    det = 1'b0;
    rd(HGC_OFF_PIN_VOLTAGE_CONTROL); `CHK("io_back", 8'h09, rv)
  endtask : t_io
  task automatic t_gpio();
    gpio_in = 8'ha5;
    rd(HGC_OFF_PIN_LEVEL); `CHK("pins_a5", 8'ha5, rv)
    wr(HGC_OFF_PIN_LEVEL, 8'h00);
    gpio_in = 8'h3c;
    rd(HGC_OFF_PIN_LEVEL); `CHK("pins_3c", 8'h3c, rv)
    rd(8'h20); `CHK("unmapped", HGC_READ_ZERO, rv)
  endtask : t_gpio
  task automatic t_master();
    wr(HGC_OFF_LOW_COUNT, 8'h02);
    wr(HGC_OFF_HIGH_COUNT, 8'h03);
    stretch = 8'h04;
    men = 1'b1;
    for (n = 0; n < 4 && scl_oe !== 1'b1; n++) @(negedge clk);
    cnt_oe(1'b1, n); `CHK("low_ph", 8, n)
    cnt_oe(1'b0, n); `CHK("high_ph", 1'b1, n >= 8 && n <= 10)
    // Mid-phase write lands on the following high phase
    wr(HGC_OFF_HIGH_COUNT, 8'h01);
    cnt_oe(1'b1, n);
    cnt_oe(1'b0, n); `CHK("high_new", 1'b1, n >= 6 && n <= 8)
    // Enable drops in a low phase, which still runs to its end
    men = 1'b0;
    stretch = 8'h00;
    repeat (24) @(negedge clk);
    `CHK("idle_oe", 1'b0, scl_oe)
    `CHK("scl_o", 1'b0, scl_o)
  endtask : t_master
  task automatic t_slave();
    sreq = 1'b1;
    @(negedge clk);
    sreq = 1'b0;
    `CHK("stretch_oe", 1'b1, scl_oe)
    n = 0;
    while (busy === 1'b1 && n < 300) begin
      n++;
      @(negedge clk);
    end
    `CHK("setup_len", 8, n)
    `CHK("setup_rel", 1'b0, scl_oe)
  endtask : t_slave
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_rx_port();
    t_io();
    t_gpio();
    t_master();
    t_slave();
    final_report();
  end
endmodule : test_hgc_regs
